// ===== verilog/tmp_pkg.sv
// Holds shared constants and types of the telemetry statistics block.
// Assumes a command layer that hands over decoded read and write word transactions.
// What this block does
// [R1] input voltage average returned on DCh
// [R2] statistics commands are read word, read-only
// [R3] bits 2:0 set averaging sample count
// [R4] bit 6 clears all averages to zero, or to the sample on a data cycle
// [R5] D1h returns input voltage minimum since clear
// [R6] D2h returns input voltage peak since clear
// [R7] DDh returns output voltage average
// [R8] averages refresh on every data cycle
// [R9] DAh returns output voltage minimum since clear
// [R10] DEh returns input current average
// [R11] D4h returns input current peak since clear
// [R12] D6h averages aux when selected, else temperature
// [R13] source select resets low, temperature tracked
// [R14] codes span 0x0000 to 0x03FF full scale
// [R15] host converts codes with DIRECT coefficients
// [R16] data cycle 11 us normal, 18 us high-performance
// [R17] value in bits 9:0; cleared minimum takes next
`default_nettype none
package tmp_pkg;
	// ---------------------------------------------------------------
	// command codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_VIN_MIN    = 8'hD1;
	localparam logic [7:0] CMD_VIN_PEAK   = 8'hD2;
	localparam logic [7:0] CMD_IIN_PEAK   = 8'hD4;
	localparam logic [7:0] CMD_TA_AVG     = 8'hD6;
	localparam logic [7:0] CMD_VOUT_MIN   = 8'hDA;
	localparam logic [7:0] CMD_VIN_AVG    = 8'hDC;
	localparam logic [7:0] CMD_VOUT_AVG   = 8'hDD;
	localparam logic [7:0] CMD_IIN_AVG    = 8'hDE;
	localparam logic [7:0] CMD_STAT_CTRL  = 8'hC0;
	localparam logic [7:0] CMD_ADC_CFG2   = 8'hC1;
	localparam logic [7:0] CMD_DEV_CFG    = 8'hC2;
	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int         AVG_CNT_LSB    = 0;
	localparam int         AVG_CNT_MSB    = 2;
	localparam int         CLR_MIN_BIT    = 5;
	localparam int         CLR_AVG_BIT    = 6;
	localparam int         CLR_PEAK_BIT   = 7;
	localparam int         AUX_SEL_BIT    = 7;
	localparam int         HI_PERF_BIT    = 3;
	localparam logic [2:0] AVG_CNT_RESET  = 3'h0;
	localparam logic       AUX_SEL_RESET  = 1'h0;
	localparam logic       HI_PERF_RESET  = 1'h0;
	localparam logic [9:0] FULL_SCALE     = 10'h3FF;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int CYCLE_NORMAL_NS  = 11000;
	localparam int CYCLE_HIPERF_NS  = 18000;
	localparam int CYCLE_NORMAL_CLK = (CYCLE_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYCLE_HIPERF_CLK = (CYCLE_HIPERF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [9:0] vin;
		logic [9:0] vout;
		logic [9:0] iin;
		logic [9:0] temp;
		logic [9:0] aux;
	} tmp_samples_t;
endpackage : tmp_pkg
`default_nettype wire

// ===== verilog/tmp_telemetry_stats.sv
// Running average, minimum and peak statistics with a read and write word command port.
// Assumes one command per request pulse and samples valid at each data cycle tick.
`default_nettype none
module tmp_telemetry_stats #(
	parameter int NORMAL_CLK = tmp_pkg::CYCLE_NORMAL_CLK,
	parameter int HIPERF_CLK = tmp_pkg::CYCLE_HIPERF_CLK
) (
	input  wire logic                 mclk,      // device clock
	input  wire logic                 rstn,      // synchronous reset, low
	input  wire tmp_pkg::tmp_samples_t samples,  // latest converter codes
	input  wire logic                 cmdValid,  // command request pulse
	input  wire logic                 cmdWrite,  // 1 write word, 0 read word
	input  wire logic [7:0]           cmdCode,   // command code
	input  wire logic [15:0]          cmdWrData, // write word data
	output logic                      cmdDone,   // answer pulse
	output logic                      cmdNack,   // refused with answer
	output logic [15:0]               rdData,    // read word data
	output logic                      cycleTick  // data cycle pulse
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [16:0] emaNext(input logic [16:0] acc,
		input logic [9:0] s, input logic [2:0] n);
		emaNext = acc + {7'h00, s} - (acc >> n);
	endfunction : emaNext

	function automatic logic [9:0] avgOf(input logic [16:0] acc, input logic [2:0] n);
		logic [16:0] sh;
		sh = acc >> n;
		avgOf = sh[9:0];
	endfunction : avgOf

	function automatic logic [15:0] word(input logic [9:0] v);
		word = {6'h00, v}; // see [R14] [R17]
	endfunction : word

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	logic [2:0]  avgCnt_reg;
	logic        auxSel_reg;
	logic        hiPerf_reg;
	logic        wrStat;
	logic        clrMin;
	logic        clrAvg;
	logic        clrPeak;

	assign wrStat  = cmdValid && cmdWrite && (cmdCode == tmp_pkg::CMD_STAT_CTRL);
	assign clrMin  = wrStat && cmdWrData[tmp_pkg::CLR_MIN_BIT];
	assign clrAvg  = wrStat && cmdWrData[tmp_pkg::CLR_AVG_BIT];
	assign clrPeak = wrStat && cmdWrData[tmp_pkg::CLR_PEAK_BIT];

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			avgCnt_reg <= tmp_pkg::AVG_CNT_RESET;
			auxSel_reg <= tmp_pkg::AUX_SEL_RESET; // see [R13]
			hiPerf_reg <= tmp_pkg::HI_PERF_RESET;
		end
		else if (cmdValid && cmdWrite)
		begin
			if (cmdCode == tmp_pkg::CMD_STAT_CTRL)
				avgCnt_reg <= cmdWrData[tmp_pkg::AVG_CNT_MSB:tmp_pkg::AVG_CNT_LSB]; // see [R3]
			if (cmdCode == tmp_pkg::CMD_ADC_CFG2)
				auxSel_reg <= cmdWrData[tmp_pkg::AUX_SEL_BIT];
			if (cmdCode == tmp_pkg::CMD_DEV_CFG)
				hiPerf_reg <= cmdWrData[tmp_pkg::HI_PERF_BIT];
		end
	end

	// ---------------------------------------------------------------
	// data cycle timer
	// ---------------------------------------------------------------
	logic [15:0] cycCnt_reg;
	logic        tick;
	logic [15:0] reload;

	assign tick   = (cycCnt_reg == 16'h0000);
	assign reload = hiPerf_reg ? 16'(HIPERF_CLK - 1) : 16'(NORMAL_CLK - 1); // see [R16]

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			cycCnt_reg <= 16'h0000;
			cycleTick  <= 1'b0;
		end
		else
		begin
			cycCnt_reg <= tick ? reload : cycCnt_reg - 16'h0001; // see [R16]
			cycleTick  <= tick;
		end
	end

	// ---------------------------------------------------------------
	// averages
	// ---------------------------------------------------------------
	logic [16:0] acc_reg [4];
	logic [9:0]  chanSample [4];

	assign chanSample[0] = samples.vin;
	assign chanSample[1] = samples.vout;
	assign chanSample[2] = samples.iin;
	assign chanSample[3] = auxSel_reg ? samples.aux : samples.temp; // see [R12]

	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (!rstn)
				acc_reg[i] <= 17'h00000;
			else if (clrAvg)
				acc_reg[i] <= tick ? {7'h00, chanSample[i]} : 17'h00000; // see [R4]
			else if (tick)
				acc_reg[i] <= emaNext(acc_reg[i], chanSample[i], avgCnt_reg); // see [R8]
		end
	end

	// ---------------------------------------------------------------
	// minimum trackers
	// ---------------------------------------------------------------
	logic [9:0] vinMin_reg;
	logic [9:0] voutMin_reg;
	logic       minEmpty_reg;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			vinMin_reg   <= 10'h000;
			voutMin_reg  <= 10'h000;
			minEmpty_reg <= 1'b1;
		end
		else if (tick)
		begin
			if (clrMin || minEmpty_reg)
			begin
				vinMin_reg  <= samples.vin;  // see [R17]
				voutMin_reg <= samples.vout; // see [R17]
			end
			else
			begin
				if (samples.vin < vinMin_reg)
					vinMin_reg <= samples.vin;   // see [R5]
				if (samples.vout < voutMin_reg)
					voutMin_reg <= samples.vout; // see [R9]
			end
			minEmpty_reg <= 1'b0;
		end
		else if (clrMin)
			minEmpty_reg <= 1'b1;
	end

	// ---------------------------------------------------------------
	// peak trackers
	// ---------------------------------------------------------------
	logic [9:0] vinPeak_reg;
	logic [9:0] iinPeak_reg;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			vinPeak_reg <= 10'h000;
			iinPeak_reg <= 10'h000;
		end
		else if (clrPeak)
		begin
			vinPeak_reg <= tick ? samples.vin : 10'h000; // see [R6]
			iinPeak_reg <= tick ? samples.iin : 10'h000; // see [R11]
		end
		else if (tick)
		begin
			if (samples.vin > vinPeak_reg)
				vinPeak_reg <= samples.vin; // see [R6]
			if (samples.iin > iinPeak_reg)
				iinPeak_reg <= samples.iin; // see [R11]
		end
	end

	// ---------------------------------------------------------------
	// command answers
	// ---------------------------------------------------------------
	logic [15:0] rdNext;
	logic        known;
	logic        roCmd;

	always_comb
	begin
		rdNext = 16'h0000;
		known  = 1'b1;
		roCmd  = 1'b1;
		unique case (cmdCode)
			tmp_pkg::CMD_VIN_AVG:  rdNext = word(avgOf(acc_reg[0], avgCnt_reg)); // see [R1]
			tmp_pkg::CMD_VOUT_AVG: rdNext = word(avgOf(acc_reg[1], avgCnt_reg)); // see [R7]
			tmp_pkg::CMD_IIN_AVG:  rdNext = word(avgOf(acc_reg[2], avgCnt_reg)); // see [R10]
			tmp_pkg::CMD_TA_AVG:   rdNext = word(avgOf(acc_reg[3], avgCnt_reg)); // see [R12]
			tmp_pkg::CMD_VIN_MIN:  rdNext = word(vinMin_reg);  // see [R5]
			tmp_pkg::CMD_VOUT_MIN: rdNext = word(voutMin_reg); // see [R9]
			tmp_pkg::CMD_VIN_PEAK: rdNext = word(vinPeak_reg); // see [R6]
			tmp_pkg::CMD_IIN_PEAK: rdNext = word(iinPeak_reg); // see [R11]
			tmp_pkg::CMD_STAT_CTRL:
			begin
				rdNext = {13'h0000, avgCnt_reg};
				roCmd  = 1'b0;
			end
			tmp_pkg::CMD_ADC_CFG2:
			begin
				rdNext = {8'h00, auxSel_reg, 7'h00};
				roCmd  = 1'b0;
			end
			tmp_pkg::CMD_DEV_CFG:
			begin
				rdNext = {12'h000, hiPerf_reg, 3'h0};
				roCmd  = 1'b0;
			end
			default:
			begin
				known = 1'b0;
				roCmd = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			cmdDone <= 1'b0;
			cmdNack <= 1'b0;
			rdData  <= 16'h0000;
		end
		else
		begin
			cmdDone <= cmdValid;
			cmdNack <= cmdValid && (!known || (cmdWrite && roCmd)); // see [R2]
			if (cmdValid && !cmdWrite && known)
				rdData <= rdNext; // see [R2]
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	logic [15:0] gap_reg;
	logic        gapOk_reg;

	always_ff @(posedge mclk)
	begin
		if (!rstn || (cmdValid && cmdWrite && cmdCode == tmp_pkg::CMD_DEV_CFG))
		begin
			gap_reg   <= 16'h0000;
			gapOk_reg <= 1'b0;
		end
		else if (tick)
		begin
			gap_reg   <= 16'h0001;
			gapOk_reg <= 1'b1;
		end
		else
			gap_reg <= gap_reg + 16'h0001;
	end

	logic        peakClrSeen_reg;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			peakClrSeen_reg <= 1'b0;
		else if (clrPeak)
			peakClrSeen_reg <= 1'b1;
		else if (tick)
			peakClrSeen_reg <= 1'b0;
	end

	tickGap_a: assert property (tick && gapOk_reg |-> // see [R16]
		gap_reg == (hiPerf_reg ? 16'(HIPERF_CLK) : 16'(NORMAL_CLK)))
		else $error("data cycle period wrong");

	tickPulse_a: assert property (tick |=> cycleTick) // see [R16]
		else $error("data cycle pulse missing");

	avgClear_a: assert property (clrAvg && !tick |=> // see [R4]
		acc_reg[0] == 17'h00000 && acc_reg[3] == 17'h00000)
		else $error("average not cleared");

	minRestart_a: assert property (clrMin && tick |=> // see [R17]
		vinMin_reg == $past(samples.vin) && voutMin_reg == $past(samples.vout))
		else $error("minimum not restarted");

	minTrack_a: assert property (tick && !clrMin && !minEmpty_reg |=> // see [R5]
		vinMin_reg <= $past(vinMin_reg) && vinMin_reg <= $past(samples.vin))
		else $error("input minimum wrong");

	voutMin_a: assert property (tick && !clrMin && !minEmpty_reg |=> // see [R9]
		voutMin_reg <= $past(voutMin_reg) && voutMin_reg <= $past(samples.vout))
		else $error("output minimum wrong");

	peakTrack_a: assert property (tick && !clrPeak |=> // see [R11]
		iinPeak_reg >= $past(samples.iin) && iinPeak_reg >= $past(iinPeak_reg))
		else $error("current peak wrong");

	peakClear_a: assert property (clrPeak && !tick |=> // see [R6]
		vinPeak_reg == 10'h000 && iinPeak_reg == 10'h000)
		else $error("peak not cleared");

	readOnly_a: assert property (cmdValid && cmdWrite // see [R2]
		&& cmdCode == tmp_pkg::CMD_VIN_PEAK |=> cmdDone && cmdNack)
		else $error("write to statistics not refused");

	cmdAnswer_a: assert property (cmdValid |=> cmdDone) // see [R2]
		else $error("command not answered");

	unknownCmd_a: assert property (cmdValid && !known |=> // see [R2]
		cmdNack && rdData == $past(rdData))
		else $error("unknown command not refused");

	avgRead_a: assert property (cmdValid && !cmdWrite // see [R1]
		&& cmdCode == tmp_pkg::CMD_VIN_AVG
		|=> !cmdNack && rdData == word($past(avgOf(acc_reg[0], avgCnt_reg))))
		else $error("average read wrong");

	srcRead_a: assert property ($past(tick, 2) && !$past(tick) && !$past(clrAvg) // see [R12]
		&& cmdValid && !cmdWrite && cmdCode == tmp_pkg::CMD_TA_AVG
		&& $past(avgCnt_reg, 2) == 3'h0 && avgCnt_reg == 3'h0
		|=> rdData == word($past(auxSel_reg, 3)
		? $past(samples.aux, 3) : $past(samples.temp, 3)))
		else $error("source select wrong");

	selReset_a: assert property (rstn && !$past(rstn) |-> !auxSel_reg) // see [R13]
		else $error("select not low after reset");

	upperZero_a: assert property (cmdDone && !cmdNack |-> // see [R17]
		rdData[15:10] == 6'h00)
		else $error("upper bits not zero");

	readCov_c: cover property (cmdValid && !cmdWrite && cmdCode == tmp_pkg::CMD_VIN_MIN
		##1 cmdDone && !cmdNack);
	clearCov_c: cover property (peakClrSeen_reg && tick);
	auxCov_c: cover property (auxSel_reg && tick && avgCnt_reg == 3'h7);
	hiPerfCov_c: cover property (tick && hiPerf_reg && gapOk_reg);
endmodule : tmp_telemetry_stats
`default_nettype wire

// ===== test/tmp_host_model.sv
// Host side of the command port: issues read and write word requests.
// Assumes the device answers on the taking edge, read at the next falling edge.
`default_nettype none
module tmp_host_model (
	input  wire logic        mclk,      // device clock
	output logic             cmdValid,  // request pulse
	output logic             cmdWrite,  // 1 write word
	output logic [7:0]       cmdCode,   // command code
	output logic [15:0]      cmdWrData, // write data
	input  wire logic        cmdDone,   // answer pulse
	input  wire logic        cmdNack,   // refusal
	input  wire logic [15:0] rdData     // read word
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmdValid = 1'h0;
		cmdWrite = 1'h0;
		cmdCode = 8'h00;
		cmdWrData = 16'h0000;
	end
	// one word transfer, statistics always read as a word
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic dn, output logic nk, output logic [15:0] q);
		@(negedge mclk);
		cmdValid <= 1'h1;
		cmdWrite <= w;
		cmdCode <= c;
		cmdWrData <= d;
		@(negedge mclk);
		dn = cmdDone;
		nk = cmdNack;
		q = rdData;
		cmdValid <= 1'h0;
		cmdCode <= ~c;
		cmdWrData <= ~d;
	endtask : xfer
endmodule : tmp_host_model
`default_nettype wire

// ===== test/tmp_telemetry_stats_tb_top.sv
// Testbench of the statistics block with a host model on its command port.
// Assumes short data cycles of 8 and 12 clocks set through the parameters.
`default_nettype none
module tmp_telemetry_stats_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  mclk, rstn, cmdValid, cmdWrite, cmdDone, cmdNack, cycleTick;
	logic [7:0]            cmdCode;
	logic [15:0]           cmdWrData, rdData;
	tmp_pkg::tmp_samples_t samples;
	int                    n_errors, total_checks, g;
	logic [7:0]            ro [8] = '{8'hD1, 8'hD2, 8'hD4, 8'hD6, 8'hDA, 8'hDC, 8'hDD, 8'hDE};
	always #5 mclk = ~mclk;
	tmp_telemetry_stats #(.NORMAL_CLK(8), .HIPERF_CLK(12)) tmp_telemetry_stats_i (
		.mclk(mclk), .rstn(rstn), .samples(samples), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .cmdDone(cmdDone),
		.cmdNack(cmdNack), .rdData(rdData), .cycleTick(cycleTick));
	tmp_host_model tmp_host_model_i (
		.mclk(mclk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
		.cmdWrData(cmdWrData), .cmdDone(cmdDone), .cmdNack(cmdNack), .rdData(rdData));
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic nk, input logic [15:0] exp);
		logic        dn, nq;
		logic [15:0] q;
		tmp_host_model_i.xfer(w, c, d, dn, nq, q);
		chk("answer", {14'h0000, 1'h1, nk}, {14'h0000, dn, nq});
		if (!w)
			chk($sformatf("word %h", c), exp, q);
	endtask : acc
	// returns at the falling edge where the data cycle pulse shows
	task automatic waitTick();
		g = 0;
		do
		begin
			@(negedge mclk);
			g++;
		end
		while (cycleTick !== 1'h1 && g < 40);
		if (g >= 40)
		begin
			n_errors++;
			final_report();
		end
	endtask : waitTick
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial
	begin
		mclk = 1'h0;
		rstn = 1'h0;
		samples = '{vin:10'h064, vout:10'h0C8, iin:10'h12C, temp:10'h032, aux:10'h190};
		repeat (12) @(negedge mclk);
		rstn = 1'h1;
		waitTick();
		waitTick();
		chk("tick gap", 16'h0008, 16'(g));
		acc(1'h0, 8'hDC, 16'h0000, 1'h0, 16'h0064);
		acc(1'h0, 8'hDD, 16'h0000, 1'h0, 16'h00C8);
		acc(1'h0, 8'hDE, 16'h0000, 1'h0, 16'h012C);
		acc(1'h0, 8'hD6, 16'h0000, 1'h0, 16'h0032);
		$display("test reset values done");
		acc(1'h1, 8'hC1, 16'h0080, 1'h0, 16'h0000);
		acc(1'h0, 8'hC1, 16'h0000, 1'h0, 16'h0080);
		waitTick();
		acc(1'h0, 8'hD6, 16'h0000, 1'h0, 16'h0190);
		samples.vin = 10'h032;
		samples.vout = 10'h384;
		samples.iin = 10'h3FF;
		waitTick();
		acc(1'h0, 8'hD1, 16'h0000, 1'h0, 16'h0032);
		acc(1'h0, 8'hD2, 16'h0000, 1'h0, 16'h0064);
		acc(1'h0, 8'hDA, 16'h0000, 1'h0, 16'h00C8);
		acc(1'h0, 8'hD4, 16'h0000, 1'h0, 16'h03FF);
		$display("test min peak done");
		samples.vin = 10'h046;
		acc(1'h1, 8'hC0, 16'h00A0, 1'h0, 16'h0000);
		waitTick();
		acc(1'h0, 8'hD1, 16'h0000, 1'h0, 16'h0046);
		acc(1'h0, 8'hD2, 16'h0000, 1'h0, 16'h0046);
		$display("test clears done");
		waitTick();
		samples.vin = 10'h064;
		acc(1'h1, 8'hC0, 16'h0041, 1'h0, 16'h0000);
		acc(1'h0, 8'hC0, 16'h0000, 1'h0, 16'h0001);
		acc(1'h0, 8'hDC, 16'h0000, 1'h0, 16'h0000);
		waitTick();
		acc(1'h0, 8'hDC, 16'h0000, 1'h0, 16'h0032);
		waitTick();
		acc(1'h0, 8'hDC, 16'h0000, 1'h0, 16'h004B);
		acc(1'h1, 8'hDC, 16'h0123, 1'h1, 16'h0000);
		acc(1'h0, 8'h00, 16'h0000, 1'h1, 16'h004B);
		$display("test averaging done");
		foreach (ro[i])
			acc(1'h1, ro[i], 16'h0000, 1'h1, 16'h0000);
		acc(1'h1, 8'hC2, 16'h0008, 1'h0, 16'h0000);
		waitTick();
		waitTick();
		chk("tick gap", 16'h000C, 16'(g));
		$display("test refusal timing done");
		rstn = 1'h0;
		repeat (2) @(negedge mclk);
		rstn = 1'h1;
		waitTick();
		acc(1'h0, 8'hD6, 16'h0000, 1'h0, 16'h0032);
		acc(1'h0, 8'hD2, 16'h0000, 1'h0, 16'h0064);
		$display("test mid-run reset done");
		final_report();
	end
endmodule : tmp_telemetry_stats_tb_top
`default_nettype wire
